// ==== design/ebu_map.vh ====
/*
 * Register map and field layout of the external bus unit.
 * Assumes inclusion by the single design file; definitions only.
 */
`ifndef EBU_MAP_VH
`define EBU_MAP_VH

// Register byte offsets (Wishbone byte addresses)
`define EBU_OFF_CTRL        8'h00
`define EBU_OFF_DEF_CFG     8'h04
`define EBU_OFF_WIN_CFG0    8'h08
`define EBU_OFF_WIN_RNG0    8'h18
`define EBU_OFF_STATUS      8'h28
`define EBU_OFF_EXT_BASE    8'h80

// Control register fields
`define EBU_CTRL_EXT_BIT    0
`define EBU_CTRL_SPACE_LSB  1
`define EBU_CTRL_SPACE_W    2
`define EBU_CTRL_RST        8'h00

// Bus configuration fields
`define EBU_CFG_MODE_LSB    0
`define EBU_CFG_MCT_LSB     2
`define EBU_CFG_MTT_BIT     6
`define EBU_CFG_ALE_BIT     7
`define EBU_CFG_RWD_BIT     8
`define EBU_CFG_RDY_BIT     9
`define EBU_CFG_CS_BIT      10
`define EBU_CFG_RST         16'h0400

// Window range select fields: base in [15:4], size code in [3:0]
`define EBU_RNG_SIZE_W      4
`define EBU_RNG_RST         16'h0000

// Bus formats
`define EBU_FMT_D8_DEMUX    2'h0
`define EBU_FMT_D8_MUX      2'h1
`define EBU_FMT_D16_DEMUX   2'h2
`define EBU_FMT_D16_MUX     2'h3

// Address space restriction codes
`define EBU_SPACE_8M        2'h0
`define EBU_SPACE_1M        2'h1
`define EBU_SPACE_256K      2'h2
`define EBU_SPACE_64K       2'h3

`endif

// ==== design/ebu_ctrl.v ====
/*
 * External bus unit: Wishbone register slave plus external bus cycle
 * engine. Accesses to the external window at EBU_OFF_EXT_BASE and above
 * become cycles on the shared and dedicated address ports.
 * Assumes the bench resolves the shared port from its output enable and
 * that all inputs are synchronous to CLK_I.
 */
`timescale 1ns/1ps
`include "ebu_map.vh"

module ebu_ctrl #(
	parameter MCT_W = 4
) (
	input  wire        CLK_I,
	input  wire        RST_I,
	input  wire        CYC_I,
	input  wire        STB_I,
	input  wire        WE_I,
	input  wire [23:0] ADR_I,
	input  wire [3:0]  SEL_I,
	input  wire [31:0] DAT_I,
	output reg  [31:0] DAT_O,
	output wire        ACK_O,
	output reg  [15:0] SHARED_PORT_O,
	output reg         SHARED_PORT_OE_O,
	input  wire [15:0] SHARED_PORT_I,
	output reg  [15:0] DEDICATED_ADDRESS_PORT_O,
	output reg  [6:0]  UPPER_ADDR_O,
	output reg         ALE_O,
	output reg         RD_N_O,
	output reg         WR_N_O,
	output reg         BHE_N_O,
	output reg  [4:0]  CS_N_O,
	input  wire        READY_N_I
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_TRI  = 3'h2;
	localparam ST_DLY  = 3'h3;
	localparam ST_DATA = 3'h4;
	localparam ST_WAIT = 3'h5;
	localparam ST_DONE = 3'h6;

	reg  [7:0]       ctrl_q;
	reg  [15:0]      cfg_q [0:4];     // 0 default, 1..4 windows
	reg  [15:0]      rng_q [1:4];
	reg  [2:0]       state_q;
	reg  [MCT_W-1:0] cnt_q;
	reg  [2:0]       sel_win_q;
	reg  [15:0]      rdata_q;
	reg              ack_q;
	reg              pend_err_q;
	reg  [22:0]      xaddr_q;
	reg              xword_q;
	reg              xhigh_q;
	wire             wb_req;
	wire             ext_hit;
	wire [2:0]       win;
	wire [15:0]      cfg;
	wire [1:0]       fmt;
	wire [1:0]       space;
	wire [22:0]      eaddr;
	integer          i;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// Range hit: base in 256-byte units, size code n gives 4 KB << n
	function in_range;
		input [15:0] rng;
		input [22:0] a;
		reg   [22:0] mask;
		begin
			// Offset bits inside the block; a shift past the top covers all
			mask = (23'h001000 << rng[3:0]) - 23'h000001;
			in_range = (rng[3:0] != 4'h0) &&
				(((a ^ {3'h0, rng[15:4], 8'h00}) & ~mask) == 23'h000000);
		end
	endfunction

	// ------------------------------------------------------------------
	// Window selection
	// ------------------------------------------------------------------
	assign wb_req  = CYC_I & STB_I;
	assign ext_hit = (ADR_I >= {16'h0000, `EBU_OFF_EXT_BASE});
	assign space   = ctrl_q[`EBU_CTRL_SPACE_LSB +: `EBU_CTRL_SPACE_W];
	// Address folded to the external space, 8 MB top
	assign eaddr   = ADR_I[22:0] - {15'h0000, `EBU_OFF_EXT_BASE};
	// Priority chain: window 4, 3, 2, 1, then the default region
	assign win = in_range(rng_q[4], eaddr) ? 3'h4 :
		in_range(rng_q[3], eaddr) ? 3'h3 :
		in_range(rng_q[2], eaddr) ? 3'h2 :
		in_range(rng_q[1], eaddr) ? 3'h1 : 3'h0;
	assign cfg = cfg_q[sel_win_q];
	assign fmt = cfg[`EBU_CFG_MODE_LSB +: 2];
	assign ACK_O = ack_q;

	// ------------------------------------------------------------------
	// Register file writes
	// ------------------------------------------------------------------
	// Writes land on the taking edge; the engine gives the ack next cycle
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q <= `EBU_CTRL_RST;
			for (i = 0; i < 5; i = i + 1)
				cfg_q[i] <= `EBU_CFG_RST;
			for (i = 1; i < 5; i = i + 1)
				rng_q[i] <= `EBU_RNG_RST;
		end else if (wb_req && WE_I && !ext_hit && !ack_q) begin
			if (ADR_I[7:0] == `EBU_OFF_CTRL)
				ctrl_q <= DAT_I[7:0];
			else if (ADR_I[7:0] >= `EBU_OFF_DEF_CFG &&
				ADR_I[7:0] < `EBU_OFF_WIN_RNG0)
				cfg_q[ADR_I[4:2] - 3'h1] <= DAT_I[15:0];
			else if (ADR_I[7:0] >= `EBU_OFF_WIN_RNG0 &&
				ADR_I[7:0] < `EBU_OFF_STATUS)
				rng_q[ADR_I[4:2] - 3'h5] <= DAT_I[15:0];
		end
	end

	// ------------------------------------------------------------------
	// Bus cycle engine
	// ------------------------------------------------------------------
	// Sequence: address, latch or tri-state, delay, cycle time, ready,
	// done. The shared port is released before any read strobe so the
	// far side never fights the address driver.
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= ST_IDLE;
			cnt_q <= {MCT_W{1'b0}};
			sel_win_q <= 3'h0;
			rdata_q <= 16'h0000;
			ack_q <= 1'b0;
			pend_err_q <= 1'b0;
			xaddr_q <= 23'h000000;
			xword_q <= 1'b0;
			xhigh_q <= 1'b0;
			DAT_O <= 32'h00000000;
			SHARED_PORT_O <= 16'h0000;
			SHARED_PORT_OE_O <= 1'b0;
			DEDICATED_ADDRESS_PORT_O <= 16'h0000;
			UPPER_ADDR_O <= 7'h00;
			ALE_O <= 1'b0;
			RD_N_O <= 1'b1;
			WR_N_O <= 1'b1;
			BHE_N_O <= 1'b1;
			CS_N_O <= 5'h1F;
		end else begin
			ack_q <= 1'b0;
			case (state_q)
			ST_IDLE: begin
				// Register access answered next cycle; external one latched
				if (wb_req && !ack_q && !ext_hit) begin
					ack_q <= 1'b1;
					DAT_O <= 32'h00000000;
					if (ADR_I[7:0] == `EBU_OFF_CTRL)
						DAT_O <= {24'h000000, ctrl_q};
					else if (ADR_I[7:0] >= `EBU_OFF_DEF_CFG &&
						ADR_I[7:0] < `EBU_OFF_WIN_RNG0)
						DAT_O <= {16'h0000, cfg_q[ADR_I[4:2] - 3'h1]};
					else if (ADR_I[7:0] >= `EBU_OFF_WIN_RNG0 &&
						ADR_I[7:0] < `EBU_OFF_STATUS)
						DAT_O <= {16'h0000, rng_q[ADR_I[4:2] - 3'h5]};
					else if (ADR_I[7:0] == `EBU_OFF_STATUS)
						DAT_O <= {24'h000000, pend_err_q, sel_win_q,
							1'b0, state_q};
				end else if (wb_req && !ack_q && ext_hit) begin
					if (!ctrl_q[`EBU_CTRL_EXT_BIT]) begin
						// Single-chip: refuse quietly, flag it
						ack_q <= 1'b1;
						DAT_O <= 32'h00000000;
						pend_err_q <= 1'b1;
					end else begin
						sel_win_q <= win;
						xword_q <= (SEL_I[1:0] == 2'b11);
						xhigh_q <= (SEL_I[1:0] == 2'b10);
						xaddr_q <= {eaddr[22:1], SEL_I[1:0] == 2'b10};
						state_q <= ST_ADDR;
					end
				end
			end
			ST_ADDR: begin
				// Address phase with chip select of the governing window
				CS_N_O <= ~(5'h01 << sel_win_q);
				DEDICATED_ADDRESS_PORT_O <= xaddr_q[15:0];
				case (space)
				`EBU_SPACE_8M:   UPPER_ADDR_O <= xaddr_q[22:16];
				`EBU_SPACE_1M:   UPPER_ADDR_O <= {3'h0, xaddr_q[19:16]};
				`EBU_SPACE_256K: UPPER_ADDR_O <= {5'h00, xaddr_q[17:16]};
				default:         UPPER_ADDR_O <= 7'h00;
				endcase
				BHE_N_O <= !(xword_q || xhigh_q);
				if (fmt[0]) begin
					SHARED_PORT_O <= xaddr_q[15:0];
					SHARED_PORT_OE_O <= 1'b1;
					ALE_O <= 1'b1;
				end
				cnt_q <= cfg[`EBU_CFG_ALE_BIT] ? {{(MCT_W-1){1'b0}}, 1'b1}
					: {MCT_W{1'b0}};
				state_q <= ST_TRI;
			end
			ST_TRI: begin
				if (cnt_q != {MCT_W{1'b0}}) begin
					cnt_q <= cnt_q - {{(MCT_W-1){1'b0}}, 1'b1};
				end else begin
					ALE_O <= 1'b0;
					SHARED_PORT_OE_O <= 1'b0;
					// One turn-around cycle when delay is set, or tri-state on a read
					cnt_q <= {{(MCT_W-1){1'b0}},
						cfg[`EBU_CFG_RWD_BIT] |
						(cfg[`EBU_CFG_MTT_BIT] & !WE_I)};
					state_q <= ST_DLY;
				end
			end
			ST_DLY: begin
				// Optional read/write delay and tri-state wait
				if (WE_I) begin
					SHARED_PORT_OE_O <= 1'b1;
					SHARED_PORT_O <= (fmt[1] || !xhigh_q) ? DAT_I[15:0]
						: {8'h00, DAT_I[15:8]};
				end
				if (cnt_q != {MCT_W{1'b0}}) begin
					// Strobes held off while the previous driver floats
					cnt_q <= cnt_q - {{(MCT_W-1){1'b0}}, 1'b1};
				end else begin
					RD_N_O <= WE_I;
					WR_N_O <= !WE_I;
					cnt_q <= cfg[`EBU_CFG_MCT_LSB +: MCT_W];
					state_q <= ST_DATA;
				end
			end
			ST_DATA: begin
				// Programmed cycle time with the strobe active
				if (cnt_q != {MCT_W{1'b0}})
					cnt_q <= cnt_q - {{(MCT_W-1){1'b0}}, 1'b1};
				else
					state_q <= ST_WAIT;
			end
			ST_WAIT: begin
				// Ready sampled; 8-bit reads mirrored on both lanes
				if (!cfg[`EBU_CFG_RDY_BIT] || !READY_N_I) begin
					if (fmt[1])
						rdata_q <= SHARED_PORT_I;
					else
						rdata_q <= {SHARED_PORT_I[7:0], SHARED_PORT_I[7:0]};
					state_q <= ST_DONE;
				end
			end
			ST_DONE: begin
				// Close the cycle: strobes and selects released, answer
				RD_N_O <= 1'b1;
				WR_N_O <= 1'b1;
				BHE_N_O <= 1'b1;
				ALE_O <= 1'b0;
				CS_N_O <= 5'h1F;
				SHARED_PORT_OE_O <= 1'b0;
				DAT_O <= {16'h0000, rdata_q};
				ack_q <= 1'b1;
				state_q <= ST_IDLE;
			end
			default: begin
				// Unused code: release the bus and fall back to idle
				RD_N_O <= 1'b1;
				WR_N_O <= 1'b1;
				BHE_N_O <= 1'b1;
				ALE_O <= 1'b0;
				CS_N_O <= 5'h1F;
				SHARED_PORT_OE_O <= 1'b0;
				state_q <= ST_IDLE;
			end
			endcase
		end
	end

endmodule // ebu_ctrl

// ==== testbench/ebu_props.sv ====
/* Port checker for ebu_ctrl, bound to the design module.
   Assumes Wishbone classic on the register side. */
`timescale 1ns/1ps
module ebu_props (
	input wire        CLK_I,
	input wire        RST_I,
	input wire        CYC_I,
	input wire        STB_I,
	input wire [23:0] ADR_I,
	input wire        ACK_O,
	input wire        SHARED_PORT_OE_O,
	input wire        ALE_O,
	input wire        RD_N_O,
	input wire        WR_N_O,
	input wire [4:0]  CS_N_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// ------------------------------
	// Bus and strobe relations
	// ------------------------------
	property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack held");
	property p_reg_ack;
		CYC_I && STB_I && !ACK_O && ADR_I < 24'h000080 |=> ACK_O;
	endproperty
	a_reg_ack: assert property (p_reg_ack)
		else $error("register ack late");
	property p_cs_one; $onehot0(~CS_N_O); endproperty
	a_cs_one: assert property (p_cs_one)
		else $error("two selects");
	property p_cs_use; !(RD_N_O && WR_N_O) |-> !(&CS_N_O); endproperty
	a_cs_use: assert property (p_cs_use)
		else $error("strobe without select");
	property p_ale_gap; ALE_O |-> RD_N_O && WR_N_O; endproperty
	a_ale_gap: assert property (p_ale_gap)
		else $error("latch overlaps strobe");
	property p_rd_tri; !RD_N_O |-> !SHARED_PORT_OE_O; endproperty
	a_rd_tri: assert property (p_rd_tri)
		else $error("driving during read");
	property p_wr_drv; !WR_N_O |-> SHARED_PORT_OE_O; endproperty
	a_wr_drv: assert property (p_wr_drv)
		else $error("write not driven");
	property p_ack_end; ACK_O |-> RD_N_O && WR_N_O; endproperty
	a_ack_end: assert property (p_ack_end)
		else $error("strobe at ack");
	// Main scenarios reached
	c_ale: cover property (ALE_O);
	c_rd: cover property (!RD_N_O);
	c_wr: cover property (!WR_N_O);
endmodule // ebu_props

bind ebu_ctrl ebu_props ebu_props_i (.CLK_I(CLK_I), .RST_I(RST_I),
	.CYC_I(CYC_I), .STB_I(STB_I), .ADR_I(ADR_I), .ACK_O(ACK_O),
	.SHARED_PORT_OE_O(SHARED_PORT_OE_O), .ALE_O(ALE_O),
	.RD_N_O(RD_N_O), .WR_N_O(WR_N_O), .CS_N_O(CS_N_O));

// ==== testbench/ebu_mem_model.sv ====
/* Far-side memory: 16 words, address latched or dedicated.
   Assumes the bench sets the mux flag and the ready wait. */
`timescale 1ns/1ps
module ebu_mem_model (
	input  wire        clk_i,
	input  wire [15:0] sp_i,
	input  wire [15:0] ded_i,
	input  wire        ale_i,
	input  wire        rd_n_i,
	input  wire        wr_n_i,
	input  wire        mux_i,
	input  wire [3:0]  wait_i,
	output reg  [15:0] sp_o,
	output wire        rdy_n_o
);
	reg  [15:0] mem_q [0:15];
	reg  [15:0] adr_q;
	reg  [3:0]  cnt_q;
	wire [15:0] adr = mux_i ? adr_q : ded_i;
	initial sp_o = 16'h0000;
	// Latch, capture, answer; released lines toggle
	always @(posedge clk_i) begin
		if (ale_i)
			adr_q <= sp_i;
		if (!wr_n_i)
			mem_q[adr[4:1]] <= sp_i;
		cnt_q <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_q + 4'h1;
		sp_o <= !rd_n_i ? mem_q[adr[4:1]] : ~sp_o;
	end
	assign rdy_n_o = cnt_q < wait_i;
endmodule // ebu_mem_model

// ==== testbench/external_bus_window_controller_tb.sv ====
/* Bench for ebu_ctrl: access table, then formats, ready, upper
   lines, single-chip and reset. Assumes ebu_mem_model far side. */
`timescale 1ns/1ps
module external_bus_window_controller_tb;
	typedef struct packed {
		logic        w;
		logic        m;
		logic [7:0]  a;
		logic [15:0] d;
		logic [15:0] e;
		logic [4:0]  cs;
	} ebu_row_t;
	logic        clk, rst, cyc, stb, we, ack, oe, ale, rd_n, wr_n, m;
	logic        bhe_n, rdy_n, bhe_s;
	logic [3:0]  sel, wt;
	logic [23:0] adr;
	logic [31:0] dat, dato;
	logic [15:0] sp_o, sp_m, ded, rdat;
	logic [6:0]  up, up_s;
	logic [4:0]  cs_n, cs_s;
	int          n, n0, cycles, comparisons, miscompares;
	ebu_row_t    rows [0:12];

	ebu_ctrl #(.MCT_W(4)) ebu_ctrl_i (.CLK_I(clk), .RST_I(rst),
		.CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
		.DAT_I(dat), .DAT_O(dato), .ACK_O(ack), .SHARED_PORT_O(sp_o),
		.SHARED_PORT_OE_O(oe), .SHARED_PORT_I(oe ? sp_o : sp_m),
		.DEDICATED_ADDRESS_PORT_O(ded), .UPPER_ADDR_O(up), .ALE_O(ale),
		.RD_N_O(rd_n), .WR_N_O(wr_n), .BHE_N_O(bhe_n), .CS_N_O(cs_n),
		.READY_N_I(rdy_n));
	ebu_mem_model ebu_mem_model_i (.clk_i(clk), .sp_i(sp_o),
		.ded_i(ded), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n),
		.mux_i(m), .wait_i(wt), .sp_o(sp_m), .rdy_n_o(rdy_n));

	// ------------------------------
	// Tasks
	// ------------------------------
	// One classic cycle; selects and upper lines gathered meanwhile
	task automatic wb(input logic w, input logic [23:0] a,
		input logic [15:0] d, input logic [3:0] s);
		{cyc, stb, we} <= {2'h3, w};
		adr <= a;
		sel <= s;
		dat <= {16'h0000, d};
		cs_s = 5'h1F;
		up_s = 7'h00;
		bhe_s = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			cs_s &= cs_n;
			up_s |= (&cs_n) ? 7'h00 : up;
			bhe_s &= bhe_n;
			n++;
		end while (ack !== 1'b1);
		rdat = dato[15:0];
		{cyc, stb} <= 2'h0;
		@(posedge clk);
	endtask
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------
	// Clock, timeout, sequence
	// ------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test;
		end
	end
	initial begin
		{rst, cyc, stb, we, m, sel, wt} = 13'h1000;
		{adr, dat} = 56'h00000000000000;
		rows = '{
			'{1'h1, 1'h0, 8'h00, 16'h0001, 16'h0000, 5'h1F},
			'{1'h0, 1'h0, 8'h00, 16'h0000, 16'h0001, 5'h1F},
			'{1'h1, 1'h0, 8'h04, 16'h0406, 16'h0000, 5'h1F},
			'{1'h1, 1'h0, 8'h90, 16'hA5A5, 16'h0000, 5'h1E},
			'{1'h0, 1'h0, 8'h90, 16'h0000, 16'hA5A5, 5'h1E},
			'{1'h0, 1'h0, 8'h40, 16'h0000, 16'h0000, 5'h1F},
			'{1'h1, 1'h0, 8'h08, 16'h0407, 16'h0000, 5'h1F},
			'{1'h1, 1'h0, 8'h18, 16'h0001, 16'h0000, 5'h1F},
			'{1'h1, 1'h1, 8'h82, 16'h1234, 16'h0000, 5'h1D},
			'{1'h0, 1'h1, 8'h82, 16'h0000, 16'h1234, 5'h1D},
			'{1'h1, 1'h0, 8'h0C, 16'h0406, 16'h0000, 5'h1F},
			'{1'h1, 1'h0, 8'h1C, 16'h0001, 16'h0000, 5'h1F},
			'{1'h0, 1'h0, 8'h82, 16'h0000, 16'h1234, 5'h1B}};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			m <= rows[i].m;
			wb(rows[i].w, {16'h0000, rows[i].a}, rows[i].d, 4'h3);
			if (!rows[i].w)
				chk(rdat, rows[i].e);
			chk({11'h000, cs_s}, {11'h000, rows[i].cs});
		end
		n0 = n;
		// Every data format on a byte transfer
		for (int f = 0; f < 4; f++) begin
			m <= f[0];
			wb(1'h1, 24'h00000C, 16'h0404 | f[15:0], 4'h3);
			wb(1'h1, 24'h000082, 16'h00C0 | f[15:0], 4'h1);
			wb(1'h0, 24'h000082, 16'h0000, 4'h1);
			chk({8'h00, rdat[7:0]}, 16'h00C0 | f[15:0]);
			chk({15'h0000, bhe_s}, 16'h0001);
		end
		// Slow device stretches the access
		{m, wt} <= 5'h06;
		wb(1'h1, 24'h00000C, 16'h0606, 4'h3);
		wb(1'h0, 24'h000082, 16'h0000, 4'h1);
		chk({15'h0000, n > n0 + 2}, 16'h0001);
		chk({8'h00, rdat[7:0]}, 16'h00C3);
		wt <= 4'h0;
		// High byte on the low lane of an 8-bit bus
		wb(1'h1, 24'h00000C, 16'h0404, 4'h3);
		wb(1'h1, 24'h000082, 16'h5A00, 4'h2);
		chk({15'h0000, bhe_s}, 16'h0000);
		wb(1'h0, 24'h000082, 16'h0000, 4'h2);
		chk({8'h00, rdat[15:8]}, 16'h005A);
		// Delay and tri-state settings stretch the access
		n0 = n;
		wb(1'h1, 24'h00000C, 16'h0544, 4'h3);
		wb(1'h0, 24'h000082, 16'h0000, 4'h2);
		chk({15'h0000, n > n0}, 16'h0001);
		chk({8'h00, rdat[15:8]}, 16'h005A);
		// Upper lines for every space size
		wb(1'h1, 24'h7F0080, 16'h5A5A, 4'h3);
		chk({9'h000, up_s}, 16'h007F);
		chk({15'h0000, bhe_s}, 16'h0000);
		wb(1'h1, 24'h000000, 16'h0003, 4'h3);
		wb(1'h1, 24'h7F0080, 16'h5A5A, 4'h3);
		chk({9'h000, up_s}, 16'h000F);
		wb(1'h1, 24'h000000, 16'h0005, 4'h3);
		wb(1'h1, 24'h7F0080, 16'h5A5A, 4'h3);
		chk({9'h000, up_s}, 16'h0003);
		wb(1'h1, 24'h000000, 16'h0007, 4'h3);
		wb(1'h1, 24'h7F0080, 16'h5A5A, 4'h3);
		chk({9'h000, up_s}, 16'h0000);
		// Single-chip mode answers at once with nothing outside
		wb(1'h1, 24'h000000, 16'h0000, 4'h3);
		wb(1'h0, 24'h000090, 16'h0000, 4'h3);
		chk(rdat, 16'h0000);
		chk(n[15:0], 16'h0002);
		chk({11'h000, cs_s}, 16'h001F);
		wb(1'h0, 24'h000028, 16'h0000, 4'h3);
		chk(rdat, 16'h0080);
		// Reset in mid-run clears control
		wb(1'h1, 24'h000000, 16'h0003, 4'h3);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wb(1'h0, 24'h000000, 16'h0000, 4'h3);
		chk(rdat, 16'h0000);
		stop_test;
	end
endmodule // external_bus_window_controller_tb
